// *** core/adc_result_pkg.sv ***
// Constants for the converter result register bank.
// Assumes a byte-wide register port supplied by the serial control front end.
package adc_result_pkg;
  localparam int unsigned data_w = 8;
  localparam int unsigned addr_w = 8;
  localparam int unsigned result_w = 16;
  localparam logic [7:0] system_voltage_result_high_addr = 8'h1f;
  localparam logic [7:0] system_voltage_result_low_addr = 8'h20;
  localparam logic [7:0] thermistor_ratio_result_high_addr = 8'h21;
  localparam logic [7:0] thermistor_ratio_result_low_addr = 8'h22;
  localparam logic [7:0] die_temperature_result_high_addr = 8'h23;
  localparam logic [7:0] die_temperature_result_low_addr = 8'h24;
  localparam logic [7:0] result_byte_reset = 8'h00;
  localparam logic [15:0] result_reset = 16'h0000;
  localparam int unsigned sign_bit = 7;
  localparam int unsigned die_reserved_bit = 7;
  localparam logic [7:0] unmapped_read = 8'h00;
  // Register reset holds the clear state this many cycles
  localparam int unsigned reg_reset_cycles = 2;
  typedef enum logic [1:0] {
    rst_idle = 2'b00,
    rst_clear = 2'b01,
    rst_done = 2'b11
  } reg_reset_state_t;
endpackage

// *** core/result_pair.sv ***
// One 16-bit result held as two byte registers, loaded as a pair.
// Assumes the converter presents a whole sample with a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
module result_pair #(
  parameter int unsigned WIDTH = 16,
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic load,
  input wire logic [WIDTH-1:0] sample,
  output logic [WIDTH-1:0] value_r
);
  // Both bytes move together; nothing latches the pair, so separate high and low reads can mix samples
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      value_r <= '0;
    end else if (load) begin
      value_r <= sample & MASK[WIDTH-1:0];
    end
  end
endmodule
`default_nettype wire

// *** core/adc_result_register_bank.sv ***
// Read-only converter result registers: system voltage, thermistor ratio, die temperature.
// Assumes a byte-wide read port from the serial control front end and a register reset strobe.
// Operation
// - System voltage is a 16-bit result, upper byte at 1fh just below the lower byte at 20h.
// - Bit 7 of each signed upper byte is the sign and the result is two's complement.
// - Thermistor result is a ratio to the regulator output, bit 9 is 50 percent, lsb 0.098 percent.
// - Thermistor ratio upper byte is at 21h and lower byte at 22h.
// - Die temperature upper byte at 23h reads bit 7 as zero and bits 6 to 0 as result 14 to 8.
// - Die temperature bit 8 weighs 128 C, span 0 to 128 C, higher bits unweighted.
// - All result registers are read-only, reset to 00h by register reset, kept on watchdog expiry.
// - Register reset returns registers to default, restarts the safety timer, then self-clears.
// - Die temperature lower byte is at 24h with lsb 0.5 C and bit 7 worth 64 C.
`timescale 1ns/100ps
`default_nettype none
module adc_result_register_bank (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [adc_result_pkg::addr_w-1:0] rd_addr,
  input wire logic rd_en,
  output logic [adc_result_pkg::data_w-1:0] rd_data_r,
  input wire logic reg_reset_req,
  output logic reg_reset_busy,
  output logic safety_timer_restart,
  input wire logic watchdog_expired,
  input wire logic sample_valid,
  input wire logic [adc_result_pkg::result_w-1:0] system_voltage_result,
  input wire logic [adc_result_pkg::result_w-1:0] thermistor_ratio_result,
  input wire logic [adc_result_pkg::result_w-1:0] die_temperature_result
);
  import adc_result_pkg::*;

  reg_reset_state_t rst_state_r;
  logic [1:0] rst_cnt_r;
  logic clear_results;
  logic [15:0] sys_v;
  logic [15:0] therm;
  logic [15:0] die_t;
  logic [7:0] rd_nxt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_state_r <= rst_idle;
      rst_cnt_r <= 2'h0;
    end else begin
      unique case (rst_state_r)
        rst_idle: begin
          rst_cnt_r <= 2'h0;
          if (reg_reset_req) begin
            rst_state_r <= rst_clear;
          end
        end
        rst_clear: begin
          rst_cnt_r <= rst_cnt_r + 2'h1;
          if (rst_cnt_r == 2'(reg_reset_cycles - 1)) begin
            rst_state_r <= rst_done;
          end
        end
        rst_done: begin
          rst_state_r <= rst_idle;
        end
        default: begin
          rst_state_r <= rst_idle;
        end
      endcase
    end
  end

  // Busy reads back as the reset bit; it self-clears after completion
  assign reg_reset_busy = (rst_state_r != rst_idle);
  assign safety_timer_restart = (rst_state_r == rst_clear) && (rst_cnt_r == 2'h0);
  // register reset clears; watchdog expiry deliberately unused
  assign clear_results = (rst_state_r == rst_clear);

  // system voltage pair, full 16-bit two's complement
  result_pair #(.WIDTH(16), .MASK(16'hffff)) u_sys_v (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(clear_results),
    .load(sample_valid),
    .sample(system_voltage_result),
    .value_r(sys_v)
  );

  // thermistor ratio, unweighted bits 14..10 forced to zero
  result_pair #(.WIDTH(16), .MASK(16'h83ff)) u_therm (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(clear_results),
    .load(sample_valid),
    .sample(thermistor_ratio_result),
    .value_r(therm)
  );

  // die temperature, bit 15 reserved as zero
  result_pair #(.WIDTH(16), .MASK(16'h7fff)) u_die_t (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(clear_results),
    .load(sample_valid),
    .sample(die_temperature_result),
    .value_r(die_t)
  );

  // address decode, unmapped reads return zero
  always_comb begin
    rd_nxt = unmapped_read;
    unique case (rd_addr)
      system_voltage_result_high_addr: rd_nxt = sys_v[15:8];
      system_voltage_result_low_addr: rd_nxt = sys_v[7:0];
      thermistor_ratio_result_high_addr: rd_nxt = therm[15:8];
      thermistor_ratio_result_low_addr: rd_nxt = therm[7:0];
      die_temperature_result_high_addr: rd_nxt = {1'b0, die_t[14:8]};
      die_temperature_result_low_addr: rd_nxt = die_t[7:0];
      default: rd_nxt = unmapped_read;
    endcase
  end

  // read-only data register, held between reads
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_r <= result_byte_reset;
    end else if (rd_en) begin
      rd_data_r <= rd_nxt;
    end
  end

  // Assertions, all on the one system clock
  // busy self clears
  reset_self_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(reg_reset_busy) |-> ##[1:4] !reg_reset_busy))
    else $error("register reset did not self clear");
  timer_restart_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rst_state_r == rst_idle && reg_reset_req |=> ##0 safety_timer_restart))
    else $error("safety timer not restarted");
  results_cleared_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clear_results |=> sys_v == result_reset && therm == result_reset
      && die_t == result_reset))
    else $error("results not cleared by register reset");
  die_reserved_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && rd_addr == die_temperature_result_high_addr |=> !rd_data_r[die_reserved_bit]))
    else $error("die reserved bit read nonzero");
  therm_unweighted_a: assert property (@(posedge sys_clk) disable iff (rst)
    (therm[14:10] == 5'h00))
    else $error("thermistor unweighted bits set");
  pair_update_a: assert property (@(posedge sys_clk) disable iff (rst)
    (sample_valid && !clear_results |=> sys_v == $past(system_voltage_result)))
    else $error("system voltage pair not loaded together");
  sign_kept_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && rd_addr == system_voltage_result_high_addr |=>
      rd_data_r[sign_bit] == $past(sys_v[15])))
    else $error("sign bit lost");
  low_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && rd_addr == system_voltage_result_low_addr |=> rd_data_r == $past(sys_v[7:0])))
    else $error("system voltage low byte wrong");
  therm_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && rd_addr == thermistor_ratio_result_high_addr |=> rd_data_r == $past(therm[15:8])))
    else $error("thermistor high byte wrong");
  die_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && rd_addr == die_temperature_result_low_addr |=> rd_data_r == $past(die_t[7:0])))
    else $error("die low byte wrong");
  watchdog_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    (watchdog_expired && !sample_valid && !clear_results |=> $stable(sys_v)))
    else $error("watchdog changed results");
  watchdog_keep_all_a: assert property (@(posedge sys_clk) disable iff (rst)
    (watchdog_expired && !sample_valid && !clear_results |=> $stable(therm) && $stable(die_t)))
    else $error("watchdog changed thermistor or die results");
  sys_high_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && rd_addr == system_voltage_result_high_addr |=>
      rd_data_r == $past(sys_v[15:8])))
    else $error("system voltage high byte wrong");
  therm_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && rd_addr == thermistor_ratio_result_low_addr |=> rd_data_r == $past(therm[7:0])))
    else $error("thermistor low byte wrong");
  die_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && rd_addr == die_temperature_result_high_addr |=>
      rd_data_r[6:0] == $past(die_t[14:8])))
    else $error("die high byte wrong");
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_en && (rd_addr < system_voltage_result_high_addr
      || rd_addr > die_temperature_result_low_addr) |=> rd_data_r == unmapped_read))
    else $error("unmapped read not zero");
  rd_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!rd_en |=> $stable(rd_data_r)))
    else $error("read data changed without a read");
  // weighted ratio bits kept, sign included; a wrong mask would drop them
  therm_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (sample_valid && !clear_results |=> therm[9:0] == $past(thermistor_ratio_result[9:0])
      && therm[15] == $past(thermistor_ratio_result[15])))
    else $error("thermistor ratio bits not loaded");
  die_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (sample_valid && !clear_results |=> die_t[14:0] == $past(die_temperature_result[14:0])))
    else $error("die temperature bits not loaded");
  busy_span_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(reg_reset_busy) |-> reg_reset_busy[*3] ##1 !reg_reset_busy))
    else $error("register reset busy span wrong");
  restart_after_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    (safety_timer_restart |-> !$past(reg_reset_busy)))
    else $error("request taken while busy");

  // Main scenarios: reset done, load, negative read, clear against load, unmapped read
  reg_reset_c: cover property (@(posedge sys_clk) disable iff (rst) $fell(reg_reset_busy));
  sample_load_c: cover property (@(posedge sys_clk) disable iff (rst) sample_valid);
  neg_read_c: cover property (@(posedge sys_clk) disable iff (rst) rd_data_r[sign_bit]);
  clear_beats_load_c: cover property (@(posedge sys_clk) disable iff (rst)
    clear_results && sample_valid);
  unmapped_read_c: cover property (@(posedge sys_clk) disable iff (rst)
    rd_en && rd_addr > die_temperature_result_low_addr);
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
// Host side of the byte-wide register read port.
// Assumes one clock and a registered answer one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end
  // One strobe per read; address scrambled after release so stale use shows
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    @(posedge sys_clk);
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the converter result register bank.
// Assumes the host model issues reads; the bench drives samples and resets.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import adc_result_pkg::*;
  logic sys_clk, rst, rd_en, req, busy, restart, wdog, sv;
  logic [7:0] rd_addr, rd_data, d;
  logic [15:0] vs, ts, dt;
  int err_count, n_compared;
  adc_result_register_bank dut (.sys_clk(sys_clk), .rst(rst), .rd_addr(rd_addr),
    .rd_en(rd_en), .rd_data_r(rd_data), .reg_reset_req(req), .reg_reset_busy(busy),
    .safety_timer_restart(restart), .watchdog_expired(wdog), .sample_valid(sv),
    .system_voltage_result(vs), .thermistor_ratio_result(ts),
    .die_temperature_result(dt));
  host_model host (.sys_clk(sys_clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Whole bank, 1fh up to 24h, against one table
  task automatic bank(input logic [7:0] e [6]);
    for (int i = 0; i < 6; i++) begin
      host.rd(8'h1f + 8'(i), d);
      chk(d, e[i]);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    #(3000 * 8);
    err_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    req = 1'b0;
    wdog = 1'b0;
    sv = 1'b0;
    vs = 16'h0000;
    ts = 16'h0000;
    dt = 16'h0000;
    err_count = 0;
    n_compared = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    host.rd(8'h30, d);
    chk(d, unmapped_read);
    bank('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("test reset values done");
    // All-ones thermistor and die samples expose the kept thermistor sign and the masked reserved and unweighted bits
    @(posedge sys_clk);
    sv <= 1'b1;
    vs <= 16'ha5c3;
    ts <= 16'hffff;
    dt <= 16'hffff;
    @(posedge sys_clk);
    sv <= 1'b0;
    vs <= 16'h1234;
    ts <= 16'h1234;
    dt <= 16'h1234;
    bank('{8'ha5, 8'hc3, 8'h83, 8'hff, 8'h7f, 8'hff});
    $display("test sample load done");
    // Watchdog expiry must leave results alone
    @(posedge sys_clk);
    wdog <= 1'b1;
    @(posedge sys_clk);
    wdog <= 1'b0;
    bank('{8'ha5, 8'hc3, 8'h83, 8'hff, 8'h7f, 8'hff});
    $display("test watchdog done");
    // Register reset: busy three cycles, restart pulse on the first
    // A sample and a second request that land while busy must both lose
    @(posedge sys_clk);
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    sv <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      sv <= 1'b0;
      req <= (i == 0);
      chk({7'h00, busy}, (i < 3) ? 8'h01 : 8'h00);
      chk({7'h00, restart}, (i == 0) ? 8'h01 : 8'h00);
    end
    bank('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("test register reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
